// ==== core/smc_pkg.sv ====
// Constants and types for the stop mode controller
package smc_pkg;
  localparam int SMC_AW = 4;
  localparam logic [SMC_AW-1:0] SMC_OFF_PWR_CTRL = 4'h0; // power_control_register
  localparam logic [SMC_AW-1:0] SMC_OFF_IRQ_FLAG = 4'h4; // ext_irq_flag_register
  localparam logic [SMC_AW-1:0] SMC_OFF_CLKD = 4'h8; // clock divide control
  localparam logic [SMC_AW-1:0] SMC_OFF_STAT = 4'hc; // status
  localparam int SMC_BIT_STOP = 1;
  localparam int SMC_BIT_BANDGAP = 2;
  localparam int SMC_BIT_RING_SEL = 1;
  localparam int SMC_BIT_RING_ACT = 3;
  localparam int SMC_NIRQ = 6;
  localparam logic [1:0] SMC_CD_DIV1 = 2'h2;
  localparam logic [1:0] SMC_CD_RST = 2'h2;
  localparam logic [16:0] SMC_FLASH_WARM = 17'h10000;
  localparam logic [16:0] SMC_XTAL_WARM = 17'h10000;
  localparam logic [31:0] SMC_BAD_ADDR = 32'hdeadbeef;
  typedef enum logic [1:0] {
    SMC_RUN = 2'b00,
    SMC_STOP = 2'b01,
    SMC_WARM = 2'b11
  } smc_state_t;
endpackage

// ==== core/smc_warm_counter.sv ====
// Down counter that times the wake-up warm-up windows
`timescale 1ns/10ps
`default_nettype none
module smc_warm_counter
  import smc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [16:0] load_val,
  input wire logic run,
  output logic done
);
  typedef struct packed {
    logic [16:0] cnt;
    logic done;
  } smc_wc_t;
  smc_wc_t q, next_q;

  // Count down while enabled; done is registered in the same cycle the count reaches zero
  always_comb begin
    next_q = q;
    if (load) begin
      next_q.cnt = load_val;
      next_q.done = 1'b0;
    end else if (run && q.cnt != 17'h0) begin
      next_q.cnt = q.cnt - 17'h1;
      next_q.done = (q.cnt == 17'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign done = q.done;
endmodule
`default_nettype wire

// ==== core/smc_top.sv ====
// Stop mode controller: stop entry, wake sources, warm-up and clock lock
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module smc_top
  import smc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [SMC_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_rst_pin,
  input wire logic supply_below_trip,
  input wire logic [SMC_NIRQ-1:0] ext_irq,
  input wire logic [SMC_NIRQ-1:0] ext_irq_en,
  input wire logic crystal_stable,
  output logic clocks_run,
  output logic cpu_run,
  output logic crystal_enable,
  output logic ring_clock_active,
  output logic [1:0] clock_divide,
  output logic stop_reset,
  output logic irq_wake,
  output logic stop_active
);
  typedef struct packed {
    smc_state_t st;
    logic stop_req;
    logic bandgap_select;
    logic ring_osc_select;
    logic ring_clock_active;
    logic clock_divide_high;
    logic clock_divide_low;
    logic xtal_wait;
    logic [SMC_NIRQ-1:0] woke_by;
    logic wake_irq;
    logic ack;
    logic [31:0] rdata;
    logic clocks_run;
    logic cpu_run;
    logic crystal_enable;
    logic stop_reset;
    logic irq_wake;
  } smc_top_t;
  smc_top_t q, next_q;

  logic flash_load;
  logic flash_done;
  logic xtal_load;
  logic xtal_done;
  logic [SMC_NIRQ-1:0] irq_hit;
  logic bus_req;

  assign bus_req = avs_read | avs_write;

  // Per-source wake qualification
  genvar gi;
  generate
    for (gi = 0; gi < SMC_NIRQ; gi++) begin : g_irq
      assign irq_hit[gi] = ext_irq[gi] & ext_irq_en[gi];
    end
  endgenerate

  // Flash and crystal timers both load on every interrupt or bandgap wake; the crystal timer counts only while the crystal is stable
  smc_warm_counter u_flash (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(flash_load),
    .load_val(SMC_FLASH_WARM),
    .run(q.st == SMC_WARM),
    .done(flash_done)
  );
  smc_warm_counter u_xtal (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(xtal_load),
    .load_val(SMC_XTAL_WARM),
    .run(q.xtal_wait & crystal_stable),
    .done(xtal_done)
  );

  // Next state of the whole controller
  always_comb begin
    next_q = q;
    flash_load = 1'b0;
    xtal_load = 1'b0;
    next_q.ack = 1'b0;
    next_q.stop_reset = 1'b0;
    next_q.irq_wake = 1'b0;
    // Bus: one wait cycle, then the answer at the second edge
    if (bus_req && !q.ack) begin
      next_q.ack = 1'b1;
      next_q.rdata = '0;
      if (avs_read) begin
        case (avs_address)
          SMC_OFF_PWR_CTRL: begin
            next_q.rdata[SMC_BIT_STOP] = q.stop_req;
            next_q.rdata[SMC_BIT_BANDGAP] = q.bandgap_select;
          end
          SMC_OFF_IRQ_FLAG: begin
            next_q.rdata[SMC_BIT_RING_SEL] = q.ring_osc_select;
            next_q.rdata[SMC_BIT_RING_ACT] = q.ring_clock_active;
          end
          SMC_OFF_CLKD: begin
            next_q.rdata[1:0] = {q.clock_divide_high, q.clock_divide_low};
          end
          SMC_OFF_STAT: begin
            next_q.rdata[SMC_NIRQ-1:0] = q.woke_by;
            next_q.rdata[8] = q.st == SMC_STOP;
            next_q.rdata[9] = q.st == SMC_WARM;
          end
          default: begin
            next_q.rdata = SMC_BAD_ADDR;
          end
        endcase
      end else if (q.st == SMC_RUN) begin
        case (avs_address)
          SMC_OFF_PWR_CTRL: begin
            next_q.bandgap_select = avs_writedata[SMC_BIT_BANDGAP];
            if (avs_writedata[SMC_BIT_STOP]) begin
              next_q.stop_req = 1'b1;
              next_q.st = SMC_STOP;
              next_q.clocks_run = 1'b0;
              next_q.cpu_run = 1'b0;
              next_q.crystal_enable = 1'b0;
            end
          end
          SMC_OFF_IRQ_FLAG: begin
            next_q.ring_osc_select = avs_writedata[SMC_BIT_RING_SEL];
          end
          SMC_OFF_CLKD: begin
            if (!q.ring_clock_active) begin
              next_q.clock_divide_high = avs_writedata[1];
              next_q.clock_divide_low = avs_writedata[0];
            end
          end
          default: begin
          end
        endcase
      end
    end
    // ring released when the crystal timer ends, even after the core resumed
    if (q.xtal_wait && xtal_done) begin
      next_q.xtal_wait = 1'b0;
      next_q.ring_clock_active = 1'b0;
    end
    case (q.st)
      SMC_RUN: begin
      end
      SMC_STOP: begin
        // bandgap reset in stop, none while deselected
        if (q.bandgap_select && supply_below_trip) begin
          next_q.stop_reset = 1'b1;
          next_q.stop_req = 1'b0;
          next_q.st = SMC_WARM;
          next_q.wake_irq = 1'b0;
        end else if (|irq_hit) begin
          next_q.stop_req = 1'b0;
          next_q.st = SMC_WARM;
          next_q.wake_irq = 1'b1;
          next_q.woke_by = irq_hit;
        end
        if (next_q.st == SMC_WARM) begin
          flash_load = 1'b1;
          xtal_load = 1'b1;
          next_q.crystal_enable = 1'b1;
          next_q.clocks_run = 1'b1;
          // ring clocks the core or execution waits
          next_q.ring_clock_active = q.ring_osc_select;
          next_q.xtal_wait = 1'b1;
          if (q.ring_osc_select) begin
            next_q.clock_divide_high = SMC_CD_DIV1[1];
            next_q.clock_divide_low = SMC_CD_DIV1[0];
          end
        end
      end
      SMC_WARM: begin
        // flash warm-up, crystal warm-up unless on ring
        if ((flash_done || !flash_load && q.cpu_run) &&
            (q.ring_clock_active || !q.xtal_wait || xtal_done)) begin
          next_q.cpu_run = 1'b1;
          next_q.st = SMC_RUN;
          next_q.irq_wake = q.wake_irq;
          next_q.wake_irq = 1'b0;
        end
      end
      default: begin
        next_q.st = SMC_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst || ext_rst_pin) begin
      q <= '0;
      q.st <= SMC_RUN;
      q.clocks_run <= 1'b1;
      q.cpu_run <= 1'b1;
      q.crystal_enable <= 1'b1;
      q.clock_divide_high <= SMC_CD_RST[1];
      q.clock_divide_low <= SMC_CD_RST[0];
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = ~q.ack;
  assign clocks_run = q.clocks_run;
  assign cpu_run = q.cpu_run;
  assign crystal_enable = q.crystal_enable;
  assign ring_clock_active = q.ring_clock_active;
  assign clock_divide = {q.clock_divide_high, q.clock_divide_low};
  assign stop_reset = q.stop_reset;
  assign irq_wake = q.irq_wake;
  assign stop_active = q.stop_req;

  // Checks beside the logic
  a_stop_halts: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_STOP |-> !clocks_run && !cpu_run)
    else $error("clocks run in stop");
  a_stop_entry: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    avs_write && !q.ack && q.st == SMC_RUN && avs_address == SMC_OFF_PWR_CTRL && avs_writedata[SMC_BIT_STOP]
    |=> stop_active && q.st == SMC_STOP)
    else $error("stop not entered");
  a_no_more_exec: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    $rose(stop_active) |-> !cpu_run)
    else $error("instruction ran after stop");
  a_irq_wakes: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_STOP && |(ext_irq & ext_irq_en) |=> q.st == SMC_WARM)
    else $error("interrupt did not wake");
  a_pin_exits: assert property (@(posedge ref_clk) disable iff (rst)
    ext_rst_pin |=> q.st == SMC_RUN && !stop_active)
    else $error("pin did not exit stop");
  a_bg_reset: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_STOP && q.bandgap_select && supply_below_trip |=> stop_reset)
    else $error("no bandgap reset");
  a_bg_off: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_STOP && !q.bandgap_select |=> !stop_reset)
    else $error("reset without bandgap");
  a_warm_hold: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_STOP ##1 q.st == SMC_WARM |-> !cpu_run [*8])
    else $error("ran before warm-up");
  a_xtal_hold: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_WARM && !ring_clock_active && q.xtal_wait && !xtal_done |=> !cpu_run)
    else $error("ran before crystal warm");
  a_div_lock: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    ring_clock_active && $past(ring_clock_active) |-> clock_divide == SMC_CD_DIV1)
    else $error("divide moved on ring");
  a_req_clear: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_WARM |-> !stop_active)
    else $error("stop bit not cleared");
  // Wake-up, clock source and bus checks
  a_ring_entry: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_STOP ##1 q.st == SMC_WARM |-> ring_clock_active == q.ring_osc_select)
    else $error("wrong clock source on wake");
  a_ring_release: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st != SMC_STOP && q.xtal_wait && xtal_done |=> !ring_clock_active && !q.xtal_wait)
    else $error("ring kept after crystal warm");
  a_div_refuse: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    ring_clock_active && avs_write && !q.ack && avs_address == SMC_OFF_CLKD |=> clock_divide == SMC_CD_DIV1)
    else $error("divide write taken on ring");
  a_irq_resume: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_WARM ##1 q.st == SMC_RUN |-> irq_wake == $past(q.wake_irq))
    else $error("interrupt not serviced on resume");
  a_wake_pulse: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    irq_wake |=> !irq_wake)
    else $error("wake pulse too long");
  a_woke_by: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_STOP && !(q.bandgap_select && supply_below_trip) && (|irq_hit)
    |=> q.woke_by == $past(irq_hit))
    else $error("waking source not recorded");
  a_warm_exit: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_WARM && !flash_done |=> !cpu_run)
    else $error("ran before flash warm");
  a_warm_no_write: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    q.st == SMC_WARM && avs_write && !q.ack |=> $stable(clock_divide) && $stable(q.ring_osc_select))
    else $error("write taken while warming");
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (rst || ext_rst_pin)
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  // Main scenarios worth seeing
  c_irq_wake: cover property (@(posedge ref_clk) irq_wake);
  c_bg_reset: cover property (@(posedge ref_clk) stop_reset);
  c_ring_run: cover property (@(posedge ref_clk) ring_clock_active && cpu_run);
  c_xtal_hold: cover property (@(posedge ref_clk) q.st == SMC_WARM && q.xtal_wait && !ring_clock_active);
  c_ring_off: cover property (@(posedge ref_clk) $fell(ring_clock_active));
endmodule
`default_nettype wire

// ==== test/smc_ext_model.sv ====
// Model of the interrupt sources, reset pin, supply monitor and crystal
`timescale 1ns/10ps
`default_nettype none
module smc_ext_model
  import smc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [SMC_NIRQ-1:0] irq_req,
  input wire logic rst_req,
  input wire logic low_req,
  input wire logic xtal_req,
  output logic [SMC_NIRQ-1:0] ext_irq,
  output logic ext_rst_pin,
  output logic supply_below_trip,
  output logic crystal_stable
);
  // Pins are unknown only until the first edge, which falls inside reset
  // sources hold their level until withdrawn
  // Pins follow requests one edge late, like a real off-chip source
  always @(posedge ref_clk) begin
    ext_irq <= irq_req;
    ext_rst_pin <= rst_req;
    supply_below_trip <= low_req;
    crystal_stable <= xtal_req;
  end
endmodule
`default_nettype wire

// ==== test/stop_mode_controller_tb_top.sv ====
// Self-checking bench for the stop mode controller
`timescale 1ns/10ps
`default_nettype none
`define CK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module stop_mode_controller_tb_top
  import smc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [SMC_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, ext_rst_pin, supply_below_trip, crystal_stable;
  logic [SMC_NIRQ-1:0] ext_irq;
  logic [SMC_NIRQ-1:0] ext_irq_en = '0;
  logic [SMC_NIRQ-1:0] irq_req = '0;
  logic rst_req = 1'b0;
  logic low_req = 1'b0;
  logic xtal_req = 1'b0;
  logic clocks_run, cpu_run, crystal_enable, ring_clock_active, stop_reset, irq_wake, stop_active;
  logic [1:0] clock_divide;
  int failures = 0;
  int num_checks = 0;
  int n_sreset = 0;
  int n_wake = 0;
  int k;

  always #10 ref_clk = ~ref_clk;

  smc_top uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_rst_pin(ext_rst_pin), .supply_below_trip(supply_below_trip),
    .ext_irq(ext_irq), .ext_irq_en(ext_irq_en), .crystal_stable(crystal_stable), .clocks_run(clocks_run),
    .cpu_run(cpu_run), .crystal_enable(crystal_enable), .ring_clock_active(ring_clock_active),
    .clock_divide(clock_divide), .stop_reset(stop_reset), .irq_wake(irq_wake), .stop_active(stop_active));

  smc_ext_model partner (.ref_clk(ref_clk), .irq_req(irq_req), .rst_req(rst_req), .low_req(low_req),
    .xtal_req(xtal_req), .ext_irq(ext_irq), .ext_rst_pin(ext_rst_pin),
    .supply_below_trip(supply_below_trip), .crystal_stable(crystal_stable));

  // Count one-cycle pulses here so none slips between checks
  always @(posedge ref_clk) begin
    if (stop_reset === 1'b1) n_sreset++;
    if (irq_wake === 1'b1) n_wake++;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [SMC_AW-1:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      conclude();
    end
  endtask

  // Withdraw the interrupt and supply requests and raise the reset pin on the same edge, for one cycle
  task automatic pin_reset();
    @(posedge ref_clk);
    irq_req <= '0;
    low_req <= 1'b0;
    rst_req <= 1'b1;
    @(posedge ref_clk);
    rst_req <= 1'b0;
    cyc(3);
  endtask

  task automatic t_reset();
    `CK("clocks_run", 1'b1, clocks_run)
    `CK("clock_divide", SMC_CD_RST, clock_divide)
    bus(1'b0, 4'h6, '0);
    `CK("unmapped", SMC_BAD_ADDR, rd)
    bus(1'b0, SMC_OFF_PWR_CTRL, '0);
    `CK("power_ctrl", 32'h0, rd)
    $display("test reset done");
  endtask

  task automatic t_stop_rst();
    bus(1'b1, SMC_OFF_PWR_CTRL, 32'h2);
    cyc(3);
    `CK("stop_active", 1'b1, stop_active)
    `CK("cpu_run", 1'b0, cpu_run)
    `CK("clocks_run", 1'b0, clocks_run)
    `CK("crystal_enable", 1'b0, crystal_enable)
    irq_req <= 6'h3f;
    low_req <= 1'b1;
    cyc(20);
    `CK("stop held", 1'b1, stop_active)
    `CK("bg resets", 0, n_sreset)
    pin_reset();
    `CK("stop cleared", 1'b0, stop_active)
    `CK("cpu back", 1'b1, cpu_run)
    $display("test stop and pin reset done");
  endtask

  task automatic t_bgs();
    bus(1'b1, SMC_OFF_PWR_CTRL, 32'h4);
    bus(1'b0, SMC_OFF_PWR_CTRL, '0);
    `CK("bandgap readback", 32'h4, rd)
    bus(1'b1, SMC_OFF_PWR_CTRL, 32'h6);
    cyc(3);
    k = n_sreset;
    low_req <= 1'b1;
    cyc(10);
    `CK("bg reset pulse", k + 1, n_sreset)
    pin_reset();
    $display("test bandgap done");
  endtask

  task automatic t_irq_loop();
    for (int i = 0; i < SMC_NIRQ; i++) begin
      ext_irq_en <= 6'h1 << i;
      bus(1'b1, SMC_OFF_PWR_CTRL, 32'h2);
      cyc(3);
      irq_req <= 6'h1 << i;
      cyc(4);
      bus(1'b0, SMC_OFF_STAT, '0);
      `CK("warming", 2'b10, rd[9:8])
      `CK("woke_by", 6'h1 << i, rd[5:0])
      pin_reset();
    end
    $display("test each interrupt done");
  endtask

  // Long wake on the ring; the crystal settles late, so the ring is still in use after resume
  task automatic t_wake();
    int n = 0;
    k = n_wake;
    ext_irq_en <= 6'h20;
    bus(1'b1, SMC_OFF_IRQ_FLAG, 32'h2);
    bus(1'b1, SMC_OFF_PWR_CTRL, 32'h2);
    cyc(3);
    irq_req <= 6'h20;
    cyc(2);
    while (cpu_run !== 1'b1 && n < 70000) begin
      @(posedge ref_clk);
      n++;
      if (n == 200) begin
        xtal_req <= 1'b1;
      end
    end
    irq_req <= '0;
    `CK("warm not short", 1'b1, n >= 65530)
    `CK("warm not long", 1'b1, n < 65560)
    if (n >= 70000) conclude();
    cyc(2);
    `CK("irq_wake", k + 1, n_wake)
    `CK("stop cleared", 1'b0, stop_active)
    `CK("on ring", 1'b1, ring_clock_active)
    bus(1'b1, SMC_OFF_CLKD, 32'h3);
    bus(1'b0, SMC_OFF_CLKD, '0);
    `CK("divide locked", SMC_CD_DIV1, rd[1:0])
    `CK("divide port", SMC_CD_DIV1, clock_divide)
    // Ring must hand over once the crystal timer has run out
    n = 0;
    while (ring_clock_active !== 1'b0 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    `CK("ring released", 1'b0, ring_clock_active)
    bus(1'b1, SMC_OFF_CLKD, 32'h3);
    bus(1'b0, SMC_OFF_CLKD, '0);
    `CK("divide free", 2'h3, rd[1:0])
    xtal_req <= 1'b0;
    pin_reset();
    $display("test interrupt wake done");
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_stop_rst();
    t_bgs();
    t_irq_loop();
    t_wake();
    conclude();
  end
endmodule
`default_nettype wire
